// *** sleep_timing_map.vh ***
// register map, reset values and timing constants of the sleep timing block
`ifndef SLEEP_TIMING_MAP_VH
`define SLEEP_TIMING_MAP_VH

////////////////////////////////////////////////////////////////////////////////
// register indices, byte address is four times the index
`define LIGHT_SLEEP_INTERVAL_IDX 8'h0A
`define SLEEP_ENTRY_DELAYS_IDX 8'h0B
`define DEEP_SLEEP_INTERVAL_IDX 8'h0C
`define SLEEP_STATUS_IDX 8'h10

////////////////////////////////////////////////////////////////////////////////
// field positions
`define CODE_HI_MSB 7
`define CODE_HI_LSB 4
`define CODE_LO_MSB 3
`define CODE_LO_LSB 0
`define STAT_LIGHT_BIT 0
`define STAT_DEEP_BIT 1
`define STAT_MOTION_BIT 2

////////////////////////////////////////////////////////////////////////////////
// reset values and fixed lower nibble of the interval registers
`define LIGHT_SLEEP_INTERVAL_RST 8'h72
`define SLEEP_ENTRY_DELAYS_RST 8'h77
`define DEEP_SLEEP_INTERVAL_RST 8'h72
`define INTERVAL_FIXED_NIBBLE 4'h2

////////////////////////////////////////////////////////////////////////////////
// timing: clock rate, tick period and the per-code units in milliseconds
`define CLK_FREQ_HZ 100000000
`define TICK_PERIOD_MS 1
`define TICK_CYCLES ((`CLK_FREQ_HZ / 1000) * `TICK_PERIOD_MS)
`define LIGHT_POLL_UNIT_MS 4
`define DEEP_POLL_UNIT_MS 32
`define LIGHT_ENTRY_UNIT_MS 128
`define DEEP_ENTRY_UNIT_MS 3840

`endif

// *** ms_tick_divider.v ***
// divider that turns the system clock into a one-cycle millisecond tick
`default_nettype none

module ms_tick_divider #(
	parameter CYCLES = 100000
) (
	input wire clk_i,
	input wire rst_i,
	output wire tick_o
);

	localparam W = (CYCLES > 1) ? $clog2(CYCLES) : 1;
	localparam integer LAST_INT = CYCLES - 1;
	localparam [W-1:0] LAST = LAST_INT[W-1:0];

	reg [W-1:0] count_ff;
	reg tick_ff;

	// free-running count, pulse on wrap
	always @(posedge clk_i) begin
		if (rst_i) begin
			count_ff <= {W{1'b0}};
			tick_ff <= 1'b0;
		end else if (count_ff == LAST) begin
			count_ff <= {W{1'b0}};
			tick_ff <= 1'b1;
		end else begin
			count_ff <= count_ff + {{(W-1){1'b0}}, 1'b1};
			tick_ff <= 1'b0;
		end
	end

	assign tick_o = tick_ff;

endmodule
`default_nettype wire

// *** motion_sync.v ***
// three-stage synchroniser with agreement filter for the motion pin
`default_nettype none

module motion_sync (
	input wire clk_i,
	input wire rst_i,
	input wire pin_i,
	output wire level_o
);

	reg s1_ff;
	reg s2_ff;
	reg s3_ff;
	reg level_ff;

	// first stage feeds only the second; change taken when stages two and three agree
	always @(posedge clk_i) begin
		if (rst_i) begin
			s1_ff <= 1'b0;
			s2_ff <= 1'b0;
			s3_ff <= 1'b0;
			level_ff <= 1'b0;
		end else begin
			s1_ff <= pin_i;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			if (s2_ff == s3_ff) begin
				level_ff <= s3_ff;
			end
		end
	end

	assign level_o = level_ff;

endmodule
`default_nettype wire

// *** sleep_mode_timing_config.v ***
// sleep level sequencer with its wishbone-mapped interval and entry registers
//
// Function
// - bits 7 to 4 of the light sleep interval register set the polling interval in light sleep.
// - the light sleep interval is (code+1) times 4 ms, so codes 0 to 15 give 4 ms to 64 ms.
// - after reset the light sleep interval code is 0111, which is 32 ms.
// - bits 7 to 4 of the deep sleep interval register step by 32 ms, giving 32 ms to 512 ms.
`include "sleep_timing_map.vh"
`default_nettype none

module sleep_mode_timing_config #(
	parameter TICK_CYCLES = `TICK_CYCLES,
	parameter LIGHT_POLL_UNIT_MS = `LIGHT_POLL_UNIT_MS,
	parameter DEEP_POLL_UNIT_MS = `DEEP_POLL_UNIT_MS,
	parameter LIGHT_ENTRY_UNIT_MS = `LIGHT_ENTRY_UNIT_MS,
	parameter DEEP_ENTRY_UNIT_MS = `DEEP_ENTRY_UNIT_MS
) (
	input wire clk_i,
	input wire rst_i,
	// wishbone classic slave
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [9:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output wire [31:0] wb_dat_o,
	output wire wb_ack_o,
	// motion indication from the sensing core, asynchronous
	input wire motion_i,
	// sleep level and sampling outputs
	output wire light_sleep_level_o,
	output wire deep_sleep_level_o,
	output wire poll_o,
	output wire wake_o
);

	////////////////////////////////////////////////////////////////////////////
	// state codes and widths

	localparam [1:0] ST_NORMAL = 2'b00;
	localparam [1:0] ST_LIGHT = 2'b01;
	localparam [1:0] ST_DEEP = 2'b10;

	localparam [19:0] LIGHT_POLL_UNIT = LIGHT_POLL_UNIT_MS[19:0];
	localparam [19:0] DEEP_POLL_UNIT = DEEP_POLL_UNIT_MS[19:0];
	localparam [19:0] LIGHT_ENTRY_UNIT = LIGHT_ENTRY_UNIT_MS[19:0];
	localparam [19:0] DEEP_ENTRY_UNIT = DEEP_ENTRY_UNIT_MS[19:0];

	// full register reset images, the code nibbles are cut out of these
	// so that a stored nibble never takes the low bits of a whole byte
	localparam [7:0] LIGHT_INTERVAL_RST = `LIGHT_SLEEP_INTERVAL_RST;
	localparam [7:0] ENTRY_DELAYS_RST = `SLEEP_ENTRY_DELAYS_RST;
	localparam [7:0] DEEP_INTERVAL_RST = `DEEP_SLEEP_INTERVAL_RST;

	////////////////////////////////////////////////////////////////////////////
	// helpers

	// span in milliseconds of a four-bit code, (code + 1) units
	function [19:0] span_ms;
		input [3:0] code;
		input [19:0] unit;
		reg [39:0] prod;
		begin
			prod = ({16'h0000, code} + 20'h0_0001) * {20'h0_0000, unit};
			span_ms = prod[19:0];
		end
	endfunction

	// word index match on the byte address
	function idx_hit;
		input [9:0] adr;
		input [7:0] idx;
		begin
			idx_hit = (adr[9:2] == idx);
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// declarations

	reg [3:0] light_sleep_poll_code_ff;
	reg [3:0] deep_sleep_poll_code_ff;
	reg [3:0] light_sleep_entry_code_ff;
	reg [3:0] deep_sleep_entry_code_ff;
	reg ack_ff;
	reg [31:0] rd_data_ff;
	reg [31:0] nxt_rd_data;
	reg [1:0] state_ff;
	reg [1:0] nxt_state;
	reg [19:0] idle_ms_ff;
	reg [19:0] nxt_idle_ms;
	reg [19:0] poll_ms_ff;
	reg [19:0] nxt_poll_ms;
	reg poll_ff;
	reg nxt_poll;
	reg wake_ff;
	reg nxt_wake;
	reg [19:0] poll_span;

	wire ms_tick;
	wire motion;
	wire bus_req;
	wire wr_en;
	wire [19:0] light_entry_span;
	wire [19:0] deep_entry_span;
	wire [7:0] light_interval_rd;
	wire [7:0] entry_rd;
	wire [7:0] deep_interval_rd;
	wire [7:0] status_rd;

	////////////////////////////////////////////////////////////////////////////
	// time base and motion input

	ms_tick_divider #(
		.CYCLES(TICK_CYCLES)
	) u_tick (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.tick_o(ms_tick)
	);

	motion_sync u_motion (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.pin_i(motion_i),
		.level_o(motion)
	);

	////////////////////////////////////////////////////////////////////////////
	// wishbone request decode, one wait state then ack

	assign bus_req = wb_cyc_i & wb_stb_i & ~ack_ff;
	assign wr_en = bus_req & wb_we_i & wb_sel_i[0];

	// ack rises one cycle after the request and drops the next cycle
	always @(posedge clk_i) begin
		if (rst_i) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= bus_req;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// configuration registers, the interval registers store only their upper code nibbles, the entry register both

	// codes written from byte lane 0, lower interval nibbles are fixed
	always @(posedge clk_i) begin
		if (rst_i) begin
			light_sleep_poll_code_ff <= LIGHT_INTERVAL_RST[`CODE_HI_MSB:`CODE_HI_LSB];
			deep_sleep_poll_code_ff <= DEEP_INTERVAL_RST[`CODE_HI_MSB:`CODE_HI_LSB];
			light_sleep_entry_code_ff <= ENTRY_DELAYS_RST[`CODE_HI_MSB:`CODE_HI_LSB];
			deep_sleep_entry_code_ff <= ENTRY_DELAYS_RST[`CODE_LO_MSB:`CODE_LO_LSB];
		end else if (wr_en) begin
			if (idx_hit(wb_adr_i, `LIGHT_SLEEP_INTERVAL_IDX)) begin
				light_sleep_poll_code_ff <= wb_dat_i[`CODE_HI_MSB:`CODE_HI_LSB];
			end
			if (idx_hit(wb_adr_i, `DEEP_SLEEP_INTERVAL_IDX)) begin
				deep_sleep_poll_code_ff <= wb_dat_i[`CODE_HI_MSB:`CODE_HI_LSB];
			end
			if (idx_hit(wb_adr_i, `SLEEP_ENTRY_DELAYS_IDX)) begin
				light_sleep_entry_code_ff <= wb_dat_i[`CODE_HI_MSB:`CODE_HI_LSB];
				deep_sleep_entry_code_ff <= wb_dat_i[`CODE_LO_MSB:`CODE_LO_LSB];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read path

	// lower interval nibble is not stored, it reads back as the fixed pattern whatever the host wrote
	assign light_interval_rd = {light_sleep_poll_code_ff, `INTERVAL_FIXED_NIBBLE};
	assign deep_interval_rd = {deep_sleep_poll_code_ff, `INTERVAL_FIXED_NIBBLE};
	assign entry_rd = {light_sleep_entry_code_ff, deep_sleep_entry_code_ff};
	assign status_rd = {5'b0_0000, motion, (state_ff == ST_DEEP), (state_ff == ST_LIGHT)};

	// read mux, unmapped words read as zero
	always @* begin
		nxt_rd_data = 32'h0000_0000;
		if (idx_hit(wb_adr_i, `LIGHT_SLEEP_INTERVAL_IDX)) begin
			nxt_rd_data = {24'h00_0000, light_interval_rd};
		end else if (idx_hit(wb_adr_i, `SLEEP_ENTRY_DELAYS_IDX)) begin
			nxt_rd_data = {24'h00_0000, entry_rd};
		end else if (idx_hit(wb_adr_i, `DEEP_SLEEP_INTERVAL_IDX)) begin
			nxt_rd_data = {24'h00_0000, deep_interval_rd};
		end else if (idx_hit(wb_adr_i, `SLEEP_STATUS_IDX)) begin
			nxt_rd_data = {24'h00_0000, status_rd};
		end
	end

	// read data registered with a read request, held until the next read request
	always @(posedge clk_i) begin
		if (rst_i) begin
			rd_data_ff <= 32'h0000_0000;
		end else if (bus_req & ~wb_we_i) begin
			rd_data_ff <= nxt_rd_data;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// spans derived from the codes

	assign light_entry_span = span_ms(light_sleep_entry_code_ff, LIGHT_ENTRY_UNIT);
	assign deep_entry_span = span_ms(deep_sleep_entry_code_ff, DEEP_ENTRY_UNIT);

	// polling span depends on the level the sequencer sits in
	always @* begin
		poll_span = span_ms(light_sleep_poll_code_ff, LIGHT_POLL_UNIT);
		if (state_ff == ST_DEEP) begin
			poll_span = span_ms(deep_sleep_poll_code_ff, DEEP_POLL_UNIT);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// sleep level sequencer

	// idle counter runs in normal and light sleep, poll counter in both sleep levels
	always @* begin
		nxt_state = state_ff;
		nxt_idle_ms = idle_ms_ff;
		nxt_poll_ms = poll_ms_ff;
		nxt_poll = 1'b0;
		nxt_wake = 1'b0;
		case (state_ff)
			ST_NORMAL: begin
				nxt_poll_ms = 20'h0_0000;
				if (motion) begin
					nxt_idle_ms = 20'h0_0000;
				end else if (ms_tick) begin
					if (idle_ms_ff + 20'h0_0001 >= light_entry_span) begin
						nxt_state = ST_LIGHT;
						nxt_idle_ms = 20'h0_0000;
					end else begin
						nxt_idle_ms = idle_ms_ff + 20'h0_0001;
					end
				end
			end
			ST_LIGHT, ST_DEEP: begin
				if (motion) begin
					nxt_state = ST_NORMAL;
					nxt_idle_ms = 20'h0_0000;
					nxt_poll_ms = 20'h0_0000;
					nxt_wake = 1'b1;
				end else if (ms_tick) begin
					// sample strobe each time the polling span runs out
					if (poll_ms_ff + 20'h0_0001 >= poll_span) begin
						nxt_poll_ms = 20'h0_0000;
						nxt_poll = 1'b1;
					end else begin
						nxt_poll_ms = poll_ms_ff + 20'h0_0001;
					end
					// deep entry time counts from the light sleep entry
					if (state_ff == ST_LIGHT) begin
						if (idle_ms_ff + 20'h0_0001 >= deep_entry_span) begin
							nxt_state = ST_DEEP;
							nxt_idle_ms = 20'h0_0000;
							nxt_poll_ms = 20'h0_0000;
						end else begin
							nxt_idle_ms = idle_ms_ff + 20'h0_0001;
						end
					end
				end
			end
			default: begin
				nxt_state = ST_NORMAL;
				nxt_idle_ms = 20'h0_0000;
				nxt_poll_ms = 20'h0_0000;
			end
		endcase
	end

	// sequencer state and output pulses
	always @(posedge clk_i) begin
		if (rst_i) begin
			state_ff <= ST_NORMAL;
			idle_ms_ff <= 20'h0_0000;
			poll_ms_ff <= 20'h0_0000;
			poll_ff <= 1'b0;
			wake_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			idle_ms_ff <= nxt_idle_ms;
			poll_ms_ff <= nxt_poll_ms;
			poll_ff <= nxt_poll;
			wake_ff <= nxt_wake;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs

	assign wb_ack_o = ack_ff;
	assign wb_dat_o = rd_data_ff;
	assign light_sleep_level_o = (state_ff == ST_LIGHT);
	assign deep_sleep_level_o = (state_ff == ST_DEEP);
	assign poll_o = poll_ff;
	assign wake_o = wake_ff;

endmodule
`default_nettype wire

// *** wb_host.sv ***
// wishbone host model standing for the controller that programs the block
`default_nettype none
module wb_host (
	input wire logic clk_i,
	input wire logic ack_i,
	input wire logic [31:0] dat_i,
	output var logic cyc_o,
	output var logic stb_o,
	output var logic we_o,
	output var logic [9:0] adr_o,
	output var logic [3:0] sel_o,
	output var logic [31:0] dat_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// idle bus at time zero
	initial begin
		{cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
	end
	// one classic cycle held until ack is sampled, then released
	task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk_i);
		cyc_o <= 1'b1;
		stb_o <= 1'b1;
		we_o <= w;
		adr_o <= a;
		sel_o <= 4'hF;
		dat_o <= d;
		do @(posedge clk_i); while (ack_i !== 1'b1);
		q = dat_i;
		cyc_o <= 1'b0;
		stb_o <= 1'b0;
		adr_o <= ~a;
		dat_o <= ~d;
	endtask
	// interval registers always get 0010 in the low nibble
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		logic [31:0] q;
		xfer(1'b1, a, {24'h0, d[7:4], (a == 10'h028 || a == 10'h030) ? 4'h2 : d[3:0]}, q);
	endtask
endmodule
`default_nettype wire

// *** sleep_timing_assertions.sv ***
// checker of bus answers, register readback and sleep timing
`default_nettype none
`include "sleep_timing_map.vh"
module sleep_timing_checker #(
	parameter TICK_CYCLES = 2,
	parameter LIGHT_POLL_UNIT_MS = 4,
	parameter DEEP_POLL_UNIT_MS = 32,
	parameter LIGHT_ENTRY_UNIT_MS = 2,
	parameter DEEP_ENTRY_UNIT_MS = 3
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [9:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic motion_i,
	input wire logic light_sleep_level_o,
	input wire logic deep_sleep_level_o,
	input wire logic poll_o,
	input wire logic wake_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic [3:0] lc_ff, dc_ff;
	logic [7:0] ec_ff;
	logic lq_ff, dq_ff;
	int g_ff, gl_ff, idle_ff, pl, pd, le, de;
	wire [7:0] ix = wb_adr_i[9:2];
	wire rd = wb_ack_o && !wb_we_i;
	// expected cycle counts from the mirrored codes
	assign pl = (lc_ff + 1) * LIGHT_POLL_UNIT_MS * TICK_CYCLES;
	assign pd = (dc_ff + 1) * DEEP_POLL_UNIT_MS * TICK_CYCLES;
	assign le = (ec_ff[7:4] + 1) * LIGHT_ENTRY_UNIT_MS * TICK_CYCLES;
	assign de = (ec_ff[3:0] + 1) * DEEP_ENTRY_UNIT_MS * TICK_CYCLES;
	// register mirror and cycle counters since poll, entry and motion
	always @(posedge clk_i) begin
		lq_ff <= light_sleep_level_o;
		dq_ff <= deep_sleep_level_o;
		g_ff <= (poll_o || lq_ff != light_sleep_level_o || dq_ff != deep_sleep_level_o) ? 1 : g_ff + 1;
		gl_ff <= (light_sleep_level_o && !lq_ff) ? 1 : gl_ff + 1;
		idle_ff <= motion_i ? 0 : idle_ff + 1;
		if (rst_i) begin
			lc_ff <= 4'h7;
			dc_ff <= 4'h7;
			ec_ff <= `SLEEP_ENTRY_DELAYS_RST;
			idle_ff <= 0;
		end else if (wb_ack_o && wb_we_i && wb_sel_i[0]) begin
			if (ix == 8'h0A) lc_ff <= wb_dat_i[7:4];
			if (ix == 8'h0B) ec_ff <= wb_dat_i[7:0];
			if (ix == 8'h0C) dc_ff <= wb_dat_i[7:4];
		end
	end
	a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not acked next cycle");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_light_readback: assert property (rd && ix == 8'h0A |-> wb_dat_o == {24'h0, lc_ff, 4'h2})
		else $error("light interval readback wrong");
	a_entry_readback: assert property (rd && ix == 8'h0B |-> wb_dat_o == {24'h0, ec_ff})
		else $error("entry delays readback wrong");
	a_deep_readback: assert property (rd && ix == 8'h0C |-> wb_dat_o == {24'h0, dc_ff, 4'h2})
		else $error("deep interval readback wrong");
	// a light poll may fall on the tick that enters deep sleep, it still has the light gap
	a_light_poll_gap: assert property (poll_o && (light_sleep_level_o || (deep_sleep_level_o && !dq_ff)) |-> g_ff inside {[pl - 1:pl + 1]})
		else $error("light poll interval wrong");
	a_deep_poll_gap: assert property (poll_o && deep_sleep_level_o && dq_ff |-> g_ff inside {[pd - 1:pd + 1]})
		else $error("deep poll interval wrong");
	a_wake_return: assert property (wake_o |-> !light_sleep_level_o && !deep_sleep_level_o && (lq_ff || dq_ff))
		else $error("wake pulse without leaving a sleep level");
	a_light_entry_time: assert property ($rose(light_sleep_level_o) |-> idle_ff inside {[le - TICK_CYCLES:le + TICK_CYCLES + 6]})
		else $error("light sleep entered at wrong time");
	a_deep_entry_time: assert property ($rose(deep_sleep_level_o) |-> gl_ff inside {[de - 1:de + 1]})
		else $error("deep sleep entered at wrong time");
endmodule
bind sleep_mode_timing_config sleep_timing_checker #(
	.TICK_CYCLES(TICK_CYCLES),
	.LIGHT_POLL_UNIT_MS(LIGHT_POLL_UNIT_MS),
	.DEEP_POLL_UNIT_MS(DEEP_POLL_UNIT_MS),
	.LIGHT_ENTRY_UNIT_MS(LIGHT_ENTRY_UNIT_MS),
	.DEEP_ENTRY_UNIT_MS(DEEP_ENTRY_UNIT_MS)
) u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
	.wb_dat_o, .wb_ack_o, .motion_i, .light_sleep_level_o, .deep_sleep_level_o, .poll_o,
	.wake_o);
`default_nettype wire

// *** tb_sleep_mode_timing_config.sv ***
// self-checking bench of the sleep timing block
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin miscompares++; \
	$display("ERROR %0t got %0h want %0h", $time, a, b); end end
module tb_sleep_mode_timing_config;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int TC = 2;
	logic clk_i = 0;
	logic rst_i = 1;
	logic motion_i = 1;
	wire cyc, stb, we, ack, light, deep, poll, wake;
	wire [9:0] adr;
	wire [3:0] sel;
	wire [31:0] wdat, rdat;
	int miscompares = 0;
	int comparisons = 0;
	int cycles = 0;
	int n;
	logic [31:0] seed = 32'h3df2_6e4a;
	logic [31:0] q;
	logic [3:0] lc, dc;
	logic [7:0] ec;
	sleep_mode_timing_config #(.TICK_CYCLES(TC), .LIGHT_ENTRY_UNIT_MS(2),
		.DEEP_ENTRY_UNIT_MS(140)) dut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .motion_i, .light_sleep_level_o(light), .deep_sleep_level_o(deep),
		.poll_o(poll), .wake_o(wake));
	wb_host h (.clk_i, .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb), .we_o(we),
		.adr_o(adr), .sel_o(sel), .dat_o(wdat));
	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic int poll_gap(input logic [3:0] c, input int unit);
		return (c + 1) * unit * TC;
	endfunction
	// read one register and compare
	task automatic rchk(input logic [9:0] a, input logic [31:0] e);
		h.xfer(1'b0, a, 32'h0, q);
		`CHK(q, e)
	endtask
	// cycles between two consecutive poll pulses
	task automatic gap(output int c);
		c = 0;
		do @(negedge clk_i); while (poll !== 1'b1);
		do begin
			@(negedge clk_i);
			c++;
		end while (poll !== 1'b1);
	endtask
	task automatic wrap_up();
		$display("counts: %0d comparisons, %0d miscompares", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	always #5 clk_i = ~clk_i;
	// hang guard
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 60000) begin
			miscompares++;
			wrap_up();
		end
	end
	// reset values, then coded intervals with corner and random codes
	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		rchk(10'h028, 32'h0000_0072);
		rchk(10'h02C, 32'h0000_0077);
		rchk(10'h030, 32'h0000_0072);
		rchk(10'h03C, 32'h0000_0000);
		rchk(10'h040, 32'h0000_0004);
		for (int k = 0; k < 4; k++) begin
			seed = lfsr(seed);
			lc = (k == 0) ? 4'h0 : (k == 1) ? 4'hF : seed[7:4];
			dc = (k == 0) ? 4'hF : (k == 1) ? 4'h0 : seed[11:8];
			ec = seed[23:16];
			h.wr(10'h028, {lc, seed[3:0]});
			h.wr(10'h02C, ec);
			h.wr(10'h030, {dc, seed[27:24]});
			rchk(10'h028, {24'h0, lc, 4'h2});
			rchk(10'h02C, {24'h0, ec});
			rchk(10'h030, {24'h0, dc, 4'h2});
			@(posedge clk_i) motion_i <= 1'b0;
			gap(n);
			`CHK(n, poll_gap(lc, 4))
			`CHK(light, 1'b1)
			rchk(10'h040, 32'h0000_0001);
			do @(negedge clk_i); while (deep !== 1'b1);
			gap(n);
			`CHK(n, poll_gap(dc, 32))
			rchk(10'h040, 32'h0000_0002);
			@(posedge clk_i) motion_i <= 1'b1;
			do @(negedge clk_i); while (wake !== 1'b1);
			@(negedge clk_i);
			`CHK({light, deep}, 2'b00)
			$display("test %0d done", k);
		end
		wrap_up();
	end
endmodule
`default_nettype wire
